// >>> shared/tws_pkg.sv
// Constants and types for the two-wire slave write guard
package tws_pkg;
    localparam int unsigned TWS_CLK_HZ = 10_000_000;
    localparam int unsigned TWS_NV_WRITE_US = 5000;
    localparam int unsigned TWS_NV_WRITE_CYC = TWS_NV_WRITE_US * (TWS_CLK_HZ / 1_000_000);
    localparam logic [2:0] TWS_SEL_POT = 3'h7;
    localparam logic [2:0] TWS_SEL_CSR = 3'h2;
    localparam logic [3:0] TWS_TYPE_ID_DEFAULT = 4'h5; // Arbitrary value
    localparam logic [3:0] TWS_BIT_LAST = 4'h7;
    localparam logic [3:0] TWS_BIT_ACK = 4'h8;
    localparam int unsigned TWS_SYNC_STAGES = 3;
    localparam logic [7:0] TWS_BYTE_ZERO = 8'h00;
    localparam int unsigned TWS_RW_POS = 0;
    localparam int unsigned TWS_SEL_LSB = 1;
    localparam int unsigned TWS_TYPE_LSB = 4;

    typedef enum logic [2:0] {
        TWS_IDLE = 3'b000,
        TWS_ADDR = 3'b001,
        TWS_ADDR_ACK = 3'b010,
        TWS_WDATA = 3'b011,
        TWS_WDATA_ACK = 3'b100,
        TWS_RDATA = 3'b101,
        TWS_RDATA_ACK = 3'b110
    } tws_state_e;
endpackage

// >>> src/tws_slave.sv
// Two-wire slave front end with write-protect gate
// How it works
// RULE_01: Protect input high refuses every nonvolatile write request.
// RULE_02: Protect high with wiper lock bit set refuses all wiper writes.
// RULE_03: Protect input treated low when floating; pull-down modelled by bench.
// RULE_04: Serial clock edges time all data shifting in and out.
// RULE_05: Data line receiver stays live even while the device drives it.
// RULE_06: Device is only a slave; it never makes clock or starts transfers.
// RULE_07: Data changes only while clock low during ordinary bits.
// RULE_08: Data change while clock high is start or stop, never data.
// RULE_09: After reset the data line is released until a transfer needs it.
// RULE_10: Every command begins with data falling while clock high.
// RULE_11: All bus activity is ignored until a start is detected.
// RULE_12: A stop, data rising while clock high, returns device to idle.
// RULE_13: After eight bits the receiver pulls data low on ninth clock.
// RULE_14: Address byte is type id, three select bits, then read bit.
// RULE_15: No address acknowledge while a nonvolatile write cycle runs.
// RULE_16: Clock and data pass synchronising registers before edge detection.
// RULE_17: A refused write changes neither wiper register nor nonvolatile store.
`timescale 1ns/100ps
module tws_slave
    import tws_pkg::*;
#(
    parameter int unsigned NV_WRITE_CYC = TWS_NV_WRITE_CYC,
    parameter logic [3:0] TYPE_ID = TWS_TYPE_ID_DEFAULT
) (
    input wire logic clk_in,                 // System clock, 10 MHz
    input wire logic rst_in,                 // Synchronous reset, active high
    input wire logic scl_in,                 // Serial clock pin from master
    input wire logic sda_in,                 // Serial data pin level
    output logic sda_out,                    // Serial data drive level, always 0
    output logic sda_oe_out,                 // Serial data drive enable
    input wire logic write_protect_in,       // Write-protect pin
    input wire logic wiper_lock_bit_in,      // Wiper lock bit from control register
    input wire logic nv_write_in,            // Current command is nonvolatile
    input wire logic [7:0] read_data_in,     // Byte to send on reads
    output logic [2:0] select_out,           // Internal address of transfer
    output logic [7:0] write_data_out,       // Received data byte
    output logic write_strobe_out,           // Accepted byte write, one cycle
    output logic write_refused_out,          // Refused byte write, one cycle
    output logic pot_write_out,              // Wiper register write, one cycle
    output logic nv_store_out,               // Nonvolatile store write, one cycle
    output logic read_strobe_out,            // Read byte fetched, one cycle
    output logic busy_out,                   // Nonvolatile cycle running
    output logic start_out,                  // Start seen, one cycle
    output logic stop_out                    // Stop seen, one cycle
);
    logic [TWS_SYNC_STAGES-1:0] scl_sync;
    logic [TWS_SYNC_STAGES-1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic wp_q;
    logic [TWS_SYNC_STAGES-1:0] wp_sync;
    tws_state_e state;
    tws_state_e next_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic nv_pending;
    logic [31:0] nv_cnt;
    logic rise_seen;

    // Third stage filters; changes count only when stages two and three agree
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_sync <= '1;
            sda_sync <= '1;
        end else begin
            scl_sync <= {scl_sync[TWS_SYNC_STAGES-2:0], scl_in}; // [RULE_16]
            sda_sync <= {sda_sync[TWS_SYNC_STAGES-2:0], sda_in}; // [RULE_05]
        end
    end

    // Filtered levels hold until the last two stages agree
    wire scl_agree = scl_sync[1] == scl_sync[2];
    wire sda_agree = sda_sync[1] == sda_sync[2];
    wire scl_now = scl_agree ? scl_sync[2] : scl_q;
    wire sda_now = sda_agree ? sda_sync[2] : sda_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_now;
            sda_q <= sda_now;
        end
    end

    wire scl_rise = scl_now && !scl_q; // [RULE_04]
    wire scl_fall = !scl_now && scl_q;
    wire start_det = scl_now && scl_q && sda_q && !sda_now; // [RULE_08] [RULE_10]
    wire stop_det = scl_now && scl_q && !sda_q && sda_now; // [RULE_08] [RULE_12]

    // Protect pin: three stages, the first is never read by logic
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp_sync <= '0;
            wp_q <= 1'b0; // [RULE_03]
        end else begin
            wp_sync <= {wp_sync[TWS_SYNC_STAGES-2:0], write_protect_in};
            if (wp_sync[1] == wp_sync[2]) begin
                wp_q <= wp_sync[2];
            end
        end
    end

    // Internal address field of an address byte
    function automatic logic [2:0] sel_of(input logic [7:0] b);
        sel_of = b[TWS_TYPE_LSB-1:TWS_SEL_LSB];
    endfunction

    wire [7:0] byte_in = {shift[6:0], sda_now};
    wire sel_ok = sel_of(shift) == TWS_SEL_POT || sel_of(shift) == TWS_SEL_CSR;
    wire addr_match = shift[7:TWS_TYPE_LSB] == TYPE_ID && sel_ok; // [RULE_14]
    wire addr_ack = addr_match && !busy_out; // [RULE_15]
    wire is_pot = select_out == TWS_SEL_POT;
    wire refuse_nv = wp_q && nv_write_in; // [RULE_01]
    // Lock refusal covers wiper writes only, never the status register
    wire refuse_lock = wp_q && wiper_lock_bit_in && is_pot; // [RULE_02]
    wire refuse = refuse_nv || refuse_lock;
    wire bit_fall = scl_fall && rise_seen;
    wire byte_done = bit_fall && bit_cnt == TWS_BIT_LAST;
    wire ack_done = bit_fall && bit_cnt == TWS_BIT_ACK;
    wire master_ack = !sda_now;

    always_comb begin
        next_state = state;
        if (stop_det) begin
            next_state = TWS_IDLE; // [RULE_12]
        end else if (start_det) begin
            next_state = TWS_ADDR; // [RULE_11]
        end else begin
            case (state)
                TWS_IDLE: next_state = TWS_IDLE; // [RULE_11]
                TWS_ADDR: if (byte_done) begin
                    next_state = addr_ack ? TWS_ADDR_ACK : TWS_IDLE;
                end
                TWS_ADDR_ACK: if (ack_done) begin
                    next_state = rw ? TWS_RDATA : TWS_WDATA;
                end
                TWS_WDATA: if (byte_done) begin
                    next_state = TWS_WDATA_ACK;
                end
                TWS_WDATA_ACK: if (ack_done) begin
                    next_state = TWS_WDATA;
                end
                TWS_RDATA: if (byte_done) begin
                    next_state = TWS_RDATA_ACK;
                end
                TWS_RDATA_ACK: if (ack_done) begin
                    next_state = master_ack ? TWS_RDATA : TWS_IDLE;
                end
                default: next_state = TWS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= TWS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit counter: 0..7 data bits, 8 is the acknowledge slot
    always_ff @(posedge clk_in) begin
        if (rst_in || start_det || state == TWS_IDLE) begin
            bit_cnt <= 4'h0;
        end else if (ack_done) begin
            bit_cnt <= 4'h0;
        end else if (bit_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // The clock fall that follows a start closes no bit, so it is not counted
    always_ff @(posedge clk_in) begin
        if (rst_in || start_det) begin
            rise_seen <= 1'b0;
        end else if (scl_rise) begin
            rise_seen <= 1'b1; // [RULE_04]
        end
    end

    // Sample on rising clock only; data is stable then
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shift <= TWS_BYTE_ZERO;
        end else if (scl_rise && bit_cnt <= TWS_BIT_LAST) begin
            shift <= byte_in; // [RULE_07]
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rw <= 1'b0;
            select_out <= 3'h0;
        end else if (state == TWS_ADDR && byte_done) begin
            rw <= shift[TWS_RW_POS];
            select_out <= sel_of(shift);
        end
    end

    // Write gate: refused bytes never reach wiper or store
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            write_data_out <= TWS_BYTE_ZERO;
            write_strobe_out <= 1'b0;
            write_refused_out <= 1'b0;
            pot_write_out <= 1'b0;
            nv_store_out <= 1'b0;
        end else begin
            write_strobe_out <= 1'b0;
            write_refused_out <= 1'b0;
            pot_write_out <= 1'b0;
            nv_store_out <= 1'b0;
            if (state == TWS_WDATA && byte_done) begin
                write_data_out <= shift;
                write_strobe_out <= !refuse; // [RULE_17]
                write_refused_out <= refuse;
                pot_write_out <= !refuse && is_pot; // [RULE_02] [RULE_17]
                nv_store_out <= !refuse && nv_write_in; // [RULE_01] [RULE_17]
            end
        end
    end

    // Nonvolatile cycle starts at the stop that closes an accepted write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            nv_pending <= 1'b0;
            busy_out <= 1'b0;
            nv_cnt <= 32'h0;
        end else begin
            if (nv_store_out) begin
                nv_pending <= 1'b1;
            end else if (start_det) begin
                nv_pending <= 1'b0;
            end
            // Loaded with length minus one so busy spans the full length
            if (stop_det && nv_pending) begin
                nv_pending <= 1'b0;
                busy_out <= 1'b1;
                nv_cnt <= NV_WRITE_CYC - 1;
            end else if (busy_out) begin
                if (nv_cnt == 32'h0) begin
                    busy_out <= 1'b0;
                end else begin
                    nv_cnt <= nv_cnt - 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx <= TWS_BYTE_ZERO;
            read_strobe_out <= 1'b0;
        end else begin
            read_strobe_out <= 1'b0;
            if (ack_done && (state == TWS_ADDR_ACK && rw || state == TWS_RDATA_ACK && master_ack)) begin
                tx <= read_data_in;
                read_strobe_out <= 1'b1;
            end else if (state == TWS_RDATA && scl_fall) begin
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // First bit of a read byte comes straight from the input byte
    wire next_tx_bit = (state == TWS_RDATA) ? tx[6] : read_data_in[7];

    // Drive only while clock low-side changes are allowed; released after reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sda_oe_out <= 1'b0; // [RULE_09]
        end else if (stop_det || start_det) begin
            sda_oe_out <= 1'b0;
        end else if (scl_fall || (state == TWS_IDLE)) begin
            case (next_state)
                TWS_ADDR_ACK, TWS_WDATA_ACK: sda_oe_out <= 1'b1; // [RULE_13]
                TWS_RDATA: sda_oe_out <= !(scl_fall && bit_cnt == TWS_BIT_LAST) && !next_tx_bit;
                default: sda_oe_out <= 1'b0; // [RULE_13]
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            start_out <= 1'b0;
            stop_out <= 1'b0;
        end else begin
            start_out <= start_det;
            stop_out <= stop_det;
        end
    end

    assign sda_out = 1'b0; // [RULE_06]
endmodule

// >>> bench/tws_props.sv
// Concurrent checks on the two-wire slave ports
`timescale 1ns/100ps
module tws_props #(
    parameter int unsigned NV_WRITE_CYC = 20
) (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic scl_in, // Serial clock
    input wire logic sda_in, // Data line
    input wire logic sda_oe_out, // Data pull
    input wire logic write_protect_in, // Protect pin
    input wire logic wiper_lock_bit_in, // Lock bit
    input wire logic write_refused_out, // Refused
    input wire logic pot_write_out, // Wiper write
    input wire logic nv_store_out, // Store write
    input wire logic busy_out, // Store busy
    input wire logic start_out, // Start pulse
    input wire logic stop_out // Stop pulse
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [3:0] wp_hi;
    logic [15:0] busy_cnt;
    // Protect counted as settled only after a few cycles, to allow for its synchroniser
    wire [3:0] next_wp_hi = !write_protect_in ? 4'h0 : (wp_hi == 4'hf ? wp_hi : wp_hi + 4'h1);
    wire [15:0] next_busy_cnt = busy_out ? busy_cnt + 16'h1 : 16'h0;
    always_ff @(posedge clk_in) begin
        wp_hi <= next_wp_hi;
        busy_cnt <= next_busy_cnt;
    end
    sequence start_seq;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_seq;
        scl_in && $rose(sda_in);
    endsequence
    reset_release_a: assert property ($fell(rst_in) |-> !sda_oe_out && !busy_out)
        else $error("line held or busy after reset");
    refused_quiet_a: assert property (write_refused_out |-> !pot_write_out && !nv_store_out)
        else $error("refused write still stored");
    nv_guard_a: assert property (nv_store_out |-> wp_hi < 4'h5)
        else $error("store write while protected");
    lock_guard_a: assert property (pot_write_out && wiper_lock_bit_in |-> wp_hi < 4'h5)
        else $error("wiper write while locked");
    start_seen_a: assert property (start_seq |-> ##[1:8] start_out)
        else $error("start not reported");
    stop_seen_a: assert property (stop_seq |-> ##[1:8] stop_out)
        else $error("stop not reported");
    drive_low_a: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data changed with clock high");
    busy_len_a: assert property ($fell(busy_out) |-> busy_cnt == NV_WRITE_CYC)
        else $error("store cycle length wrong");
    busy_noack_a: assert property ($rose(sda_oe_out) |-> !busy_out)
        else $error("acknowledge while busy");
endmodule

// >>> bench/tws_master.sv
// Behavioural two-wire bus master
`timescale 1ns/100ps
module tws_master (
    output logic scl_out, // Serial clock
    output logic sda_low_out, // Pulls data low
    input wire logic sda_in // Resolved data
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // 800 ns bit, 500 low: leaves the slave time to move its pull while clock low
    task automatic bit_io(input logic b, output logic r);
        scl_out = 1'b0;
        #250 sda_low_out = !b;
        #250 scl_out = 1'b1;
        #150 r = sda_in;
        #150 scl_out = 1'b0;
    endtask
    task automatic start();
        #287 sda_low_out = 1'b0;
        #250 scl_out = 1'b1;
        #300 sda_low_out = 1'b1;
        #300 scl_out = 1'b0;
    endtask
    task automatic stop();
        #250 sda_low_out = 1'b1;
        #250 scl_out = 1'b1;
        #300 sda_low_out = 1'b0;
    endtask
    task automatic put(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        acked = !r;
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r); // Refuse more data
    endtask
endmodule

// >>> bench/two_wire_slave_write_guard_bench.sv
// Self-checking bench for the two-wire slave write guard
`timescale 1ns/100ps
module two_wire_slave_write_guard_bench;
    import tws_pkg::*;
    localparam int unsigned NV_CYC = 200;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wp_en = 1'b0;
    logic wp_lvl = 1'b0;
    logic wiper_lock_bit_in = 1'b0;
    logic nv_write_in = 1'b0;
    logic [7:0] read_data_in = 8'h00;
    logic scl_in, m_low, sda_out, sda_oe_out, write_strobe_out, write_refused_out, pot_write_out, nv_store_out;
    logic read_strobe_out, busy_out, start_out, stop_out;
    logic [2:0] select_out;
    logic [7:0] write_data_out;
    int failures = 0;
    int checks_done = 0;
    int n_ref, n_pot, n_nv, n_rd;
    logic [7:0] exp_q[$];
    wire sda_in = !(m_low || (sda_oe_out === 1'b1 && !sda_out)); // Pull-up when released
    wire write_protect_in = wp_en ? wp_lvl : 1'b0; // Pull-down when floating
    always #50 clk_in = ~clk_in;
    tws_slave #(.NV_WRITE_CYC(NV_CYC)) tws_slave_i (.clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
        .write_protect_in, .wiper_lock_bit_in, .nv_write_in, .read_data_in, .select_out, .write_data_out,
        .write_strobe_out, .write_refused_out, .pot_write_out, .nv_store_out, .read_strobe_out, .busy_out,
        .start_out, .stop_out);
    tws_master tws_master_i (.scl_out(scl_in), .sda_low_out(m_low), .sda_in(sda_in));
    always @(posedge clk_in) begin
        n_ref += int'(write_refused_out === 1'b1);
        n_pot += int'(pot_write_out === 1'b1);
        n_nv += int'(nv_store_out === 1'b1);
        n_rd += int'(read_strobe_out === 1'b1);
    end
    // Model of accepted writes: every strobe must match the next expected byte
    always @(negedge clk_in) begin
        if (write_strobe_out === 1'b1 && exp_q.size() == 0) begin
            failures++;
            $display("[FAIL] %0t unexpected accepted write", $time);
        end else if (write_strobe_out === 1'b1) begin
            chk_byte(write_data_out, exp_q.pop_front());
        end
    end
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    // One framed transfer; reads end with a refused acknowledge
    task automatic frame(input logic [7:0] addr, input logic [7:0] data, output logic acked);
        logic [7:0] rd;
        n_ref = 0;
        n_pot = 0;
        n_nv = 0;
        n_rd = 0;
        tws_master_i.start();
        tws_master_i.put(addr, acked);
        chk_byte({5'h00, select_out}, {5'h00, addr[3:1]});
        if (acked && addr[0]) begin
            tws_master_i.get(rd);
            chk_byte(rd, read_data_in);
            chk_bit(n_rd == 1, 1'b1);
        end else if (acked) begin
            tws_master_i.put(data, acked);
        end
        tws_master_i.stop();
        repeat (8) @(negedge clk_in);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        failures++;
        end_of_test();
    end
    initial begin
        logic acked;
        logic prot;
        logic refuse;
        logic [7:0] d;
        void'($urandom(10));
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(negedge clk_in);
        chk_bit(sda_oe_out, 1'b0);
        tws_master_i.put({TWS_TYPE_ID_DEFAULT, TWS_SEL_POT, 1'b0}, acked);
        chk_bit(acked, 1'b0);
        $display("test no start done");
        for (int s = 0; s < 9; s++) begin
            d = {s == 8 ? ~TWS_TYPE_ID_DEFAULT : TWS_TYPE_ID_DEFAULT, 3'(s == 8 ? 7 : s), 1'b0};
            if (s == 2 || s == 7) exp_q.push_back(8'h00);
            frame(d, 8'h00, acked);
            chk_bit(acked, s == 2 || s == 7);
        end
        $display("test select decode done");
        for (int k = 0; k < 8; k++) begin
            d = 8'($urandom);
            @(posedge clk_in);
            wp_en <= k[2] | 1'($urandom);
            wp_lvl <= k[2] | 1'($urandom);
            wiper_lock_bit_in <= k[1];
            nv_write_in <= k[0];
            read_data_in <= 8'($urandom);
            @(negedge clk_in);
            prot = wp_en && wp_lvl;
            refuse = prot && (k[0] || k[1]);
            if (!refuse) exp_q.push_back(d);
            frame({TWS_TYPE_ID_DEFAULT, TWS_SEL_POT, 1'b0}, d, acked);
            chk_bit(n_ref == 1, refuse);
            chk_bit(n_pot == 1, !refuse);
            chk_bit(n_nv == 1, !refuse && k[0]);
            chk_bit(busy_out, !refuse && k[0]);
            if (!refuse) begin
                chk_byte(write_data_out, d);
            end
            if (busy_out === 1'b1) begin
                frame({TWS_TYPE_ID_DEFAULT, TWS_SEL_POT, 1'b1}, 8'h00, acked);
                chk_bit(acked, 1'b0);
                for (int i = 0; i < 400 && busy_out !== 1'b0; i++) begin
                    @(negedge clk_in);
                end
                frame({TWS_TYPE_ID_DEFAULT, TWS_SEL_POT, 1'b1}, 8'h00, acked);
                chk_bit(acked, 1'b1);
            end
            $display("test protect case %0d done", k);
        end
        chk_bit(exp_q.size() == 0, 1'b1);
        end_of_test();
    end
endmodule
bind tws_slave tws_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) tws_props_i (.clk_in, .rst_in, .scl_in, .sda_in,
    .sda_oe_out, .write_protect_in, .wiper_lock_bit_in, .write_refused_out, .pot_write_out, .nv_store_out,
    .busy_out, .start_out, .stop_out);
